// ---- logic/temp_monitor_config_limits.sv ----
// configuration, conversion pacing, limits and multipurpose pin of the monitor
// assumes the serial front end delivers decoded pointer reads and writes,
// and that limit flags and measurements come from logic on the same clock
`timescale 1ns/1ps

module temp_monitor_config_limits #(
   parameter int TICK_CYC = temp_cfg_pkg::TICK_CYC,
   parameter int CONV_CYC = temp_cfg_pkg::CONV_CYC
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wr_en,
   input wire logic [7:0] wr_ptr,
   input wire logic [7:0] wr_data,
   input wire logic rd_en,
   input wire logic [7:0] rd_ptr,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic rd_hit,
   input wire logic [7:0] local_meas,
   input wire logic [7:0] remote_meas,
   input wire logic flag_local_high,
   input wire logic flag_local_low,
   input wire logic flag_remote_high,
   input wire logic flag_remote_low,
   input wire logic flag_open,
   input wire logic alert_ack,
   output logic conv_start,
   output logic conv_busy,
   output logic conv_done,
   output logic local_above,
   output logic local_below,
   output logic remote_above,
   output logic irq_output_gate,
   output logic shutdown_ctl,
   output logic pin_function_select,
   output logic range_ext,
   output logic [3:0] rate_code,
   output logic irq_latch,
   output logic mp_pin_o,
   output logic mp_pin_oe
);

   logic [7:0] cfg_r;
   logic [7:0] rate_r;
   logic [7:0] lhi_r;
   logic [7:0] llo_r;
   logic [7:0] rhi_r;
   temp_cfg_pkg::conv_state_t state_r;
   temp_cfg_pkg::conv_state_t state_nxt;
   logic [31:0] conv_cnt_r;
   logic [temp_cfg_pkg::PERIOD_W-1:0] period_cnt_r;
   logic [temp_cfg_pkg::PERIOD_W-1:0] period_len;
   logic tick;
   logic oneshot_wr;
   logic conv_end;
   logic period_up;
   logic any_flag;
   logic irq_latch_nxt;
   logic pin_drive;

   assign irq_output_gate = cfg_r[temp_cfg_pkg::CFG_GATE_BIT];
   assign shutdown_ctl = cfg_r[temp_cfg_pkg::CFG_SD_BIT];
   assign pin_function_select = cfg_r[temp_cfg_pkg::CFG_PINF_BIT];
   assign range_ext = cfg_r[temp_cfg_pkg::CFG_RANGE_BIT]; // R08
   assign rate_code = rate_r[3:0];
   assign conv_busy = (state_r == temp_cfg_pkg::ST_CONV);
   assign mp_pin_o = 1'b0;
   assign mp_pin_oe = pin_drive;

   // register writes; reserved bits are dropped so they read back as zero
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfg_r <= temp_cfg_pkg::CFG_RST; // R01
         rate_r <= temp_cfg_pkg::RATE_RST; // R12
         lhi_r <= temp_cfg_pkg::LHI_RST; // R13
         llo_r <= temp_cfg_pkg::LLO_RST; // R14
         rhi_r <= temp_cfg_pkg::RHI_RST; // R15
      end
      else if (wr_en)
      begin
         unique case (wr_ptr)
            temp_cfg_pkg::WR_CFG: cfg_r <= wr_data & temp_cfg_pkg::CFG_WR_MASK; // R01 R09
            temp_cfg_pkg::WR_RATE: rate_r <= wr_data & temp_cfg_pkg::RATE_WR_MASK; // R10
            temp_cfg_pkg::WR_LHI: lhi_r <= wr_data; // R13
            temp_cfg_pkg::WR_LLO: llo_r <= wr_data; // R14
            temp_cfg_pkg::WR_RHI: rhi_r <= wr_data; // R15
            default: ;
         endcase
      end
   end

   // write-only trigger; no read pointer decodes to it
   assign oneshot_wr = wr_en && (wr_ptr == temp_cfg_pkg::WR_ONESHOT); // R18

   // read port: one cycle latency, unmapped pointers answer zero with rd_hit low
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         rd_hit <= 1'b0;
      end
      else
      begin
         rd_valid <= rd_en;
         if (rd_en)
         begin
            rd_hit <= 1'b1;
            unique case (rd_ptr)
               temp_cfg_pkg::RD_CFG: rd_data <= cfg_r; // R01 R20
               temp_cfg_pkg::RD_RATE: rd_data <= rate_r; // R10
               temp_cfg_pkg::RD_LHI: rd_data <= lhi_r; // R13
               temp_cfg_pkg::RD_LLO: rd_data <= llo_r; // R14
               temp_cfg_pkg::RD_RHI: rd_data <= rhi_r; // R15
               default:
               begin
                  rd_data <= 8'h00;
                  rd_hit <= 1'b0;
               end
            endcase
         end
      end
   end

   // period timer restarts at each conversion start so the spacing is exact
   rate_tick #(
      .DIV(TICK_CYC)
   ) u_tick (
      .clk(clk),
      .arst_n(arst_n),
      .clr(conv_start),
      .tick(tick)
   );

   assign period_len = temp_cfg_pkg::period_ticks(rate_r[3:0]); // R12 R19
   assign period_up = (period_cnt_r >= period_len);

   // saturating tick count since the last start; starts full for an early first sample
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         period_cnt_r <= temp_cfg_pkg::PERIOD_SAT;
      end
      else if (conv_start)
      begin
         period_cnt_r <= '0;
      end
      else if (tick && (period_cnt_r != temp_cfg_pkg::PERIOD_SAT))
      begin
         period_cnt_r <= period_cnt_r + 10'h001;
      end
   end

   // conversion length is fixed; the rate only moves the idle gap
   assign conv_end = (state_r == temp_cfg_pkg::ST_CONV) &&
      (conv_cnt_r == 32'(CONV_CYC - 1)); // R11

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         conv_cnt_r <= 32'h00000000;
      end
      else if (state_r != temp_cfg_pkg::ST_CONV)
      begin
         conv_cnt_r <= 32'h00000000;
      end
      else
      begin
         conv_cnt_r <= conv_cnt_r + 32'h00000001;
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         temp_cfg_pkg::ST_WAIT:
         begin
            if (shutdown_ctl)
            begin
               state_nxt = temp_cfg_pkg::ST_SHUT; // R04
            end
            else if (period_up)
            begin
               state_nxt = temp_cfg_pkg::ST_CONV; // R03
            end
         end
         temp_cfg_pkg::ST_CONV:
         begin
            // a running conversion always completes before shutdown takes hold
            if (conv_end)
            begin
               state_nxt = shutdown_ctl ? temp_cfg_pkg::ST_SHUT : temp_cfg_pkg::ST_WAIT; // R04
            end
         end
         temp_cfg_pkg::ST_SHUT:
         begin
            if (!shutdown_ctl || oneshot_wr)
            begin
               state_nxt = temp_cfg_pkg::ST_CONV; // R05 R06
            end
         end
         default: state_nxt = temp_cfg_pkg::ST_WAIT;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= temp_cfg_pkg::ST_WAIT;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign conv_start = (state_r != temp_cfg_pkg::ST_CONV) && (state_nxt == temp_cfg_pkg::ST_CONV);

   // threshold compares taken when a conversion completes; unsigned works in both
   // ranges since the extended format is offset binary
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         conv_done <= 1'b0;
         local_above <= 1'b0;
         local_below <= 1'b0;
         remote_above <= 1'b0;
      end
      else
      begin
         conv_done <= conv_end;
         if (conv_end)
         begin
            local_above <= (local_meas > lhi_r); // R13
            local_below <= (local_meas < llo_r); // R14
            remote_above <= (remote_meas > rhi_r); // R15
         end
      end
   end

   // interrupt latch: a new flag wins over an acknowledge in the same cycle
   assign any_flag = flag_local_high || flag_local_low || flag_remote_high ||
      flag_remote_low || flag_open;

   always_comb
   begin
      irq_latch_nxt = irq_latch;
      if (!pin_function_select && any_flag)
      begin
         irq_latch_nxt = 1'b1; // R16
      end
      else if (alert_ack && !any_flag)
      begin
         irq_latch_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irq_latch <= 1'b0;
      end
      else
      begin
         irq_latch <= irq_latch_nxt;
      end
   end

   // open-drain pin: enable high pulls it low
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_drive <= 1'b0;
      end
      else if (pin_function_select)
      begin
         pin_drive <= flag_local_high || flag_remote_high; // R07 R17
      end
      else
      begin
         pin_drive <= irq_latch_nxt && !irq_output_gate; // R02 R16
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   property p_cfg_write;
      wr_en && (wr_ptr == temp_cfg_pkg::WR_CFG) |=> (cfg_r == ($past(wr_data) & 8'hE4));
   endproperty
   a_cfg_write: assert property (p_cfg_write) // R01
      else $error("configuration write not stored");

   property p_write_read;
      wr_en && (wr_ptr == temp_cfg_pkg::WR_LHI) ##1 rd_en && (rd_ptr == temp_cfg_pkg::RD_LHI)
         |=> rd_valid && rd_hit && (rd_data == $past(wr_data, 2));
   endproperty
   a_write_read: assert property (p_write_read) // R20
      else $error("threshold write not seen on next read");

   property p_gate;
      !pin_function_select && irq_output_gate ##1 !pin_function_select |-> !mp_pin_oe;
   endproperty
   a_gate: assert property (p_gate) // R02
      else $error("gated interrupt pin still driven");

   property p_second_overtemp_out_low_only;
      pin_function_select && !flag_local_high && !flag_remote_high |=> !mp_pin_oe;
   endproperty
   a_second_overtemp_out_low_only: assert property (p_second_overtemp_out_low_only) // R17
      else $error("low flags drove the pin in over-temperature mode");

   property p_flag_sets_latch;
      !pin_function_select && any_flag |=> irq_latch;
   endproperty
   a_flag_sets_latch: assert property (p_flag_sets_latch) // R16
      else $error("flag did not set interrupt latch");

   property p_finish_then_stop;
      conv_end && shutdown_ctl |=> (state_r == temp_cfg_pkg::ST_SHUT) && conv_done;
   endproperty
   a_finish_then_stop: assert property (p_finish_then_stop) // R04
      else $error("shutdown not entered after conversion");

   property p_shut_holds_conv;
      (state_r == temp_cfg_pkg::ST_CONV) && !conv_end |=> (state_r == temp_cfg_pkg::ST_CONV);
   endproperty
   a_shut_holds_conv: assert property (p_shut_holds_conv) // R04 R11
      else $error("conversion cut short");

   property p_resume;
      (state_r == temp_cfg_pkg::ST_SHUT) && !shutdown_ctl |-> conv_start ##1 conv_busy;
   endproperty
   a_resume: assert property (p_resume) // R05
      else $error("conversions not resumed");

   property p_oneshot;
      (state_r == temp_cfg_pkg::ST_SHUT) && oneshot_wr |-> conv_start ##1 conv_busy;
   endproperty
   a_oneshot: assert property (p_oneshot) // R06
      else $error("one-shot did not start a conversion");

   property p_fast_code;
      (rate_r[3:0] >= 4'h9) |-> (period_len == 10'h001);
   endproperty
   a_fast_code: assert property (p_fast_code) // R19
      else $error("high rate code not at fastest rate");

   property p_default_rate;
      (rate_r[3:0] == 4'h8) |-> (period_len == 10'h002);
   endproperty
   a_default_rate: assert property (p_default_rate) // R12
      else $error("default rate period wrong");

   property p_continuous;
      (state_r == temp_cfg_pkg::ST_WAIT) && !shutdown_ctl && period_up |-> conv_start;
   endproperty
   a_continuous: assert property (p_continuous) // R03
      else $error("due conversion not started");

   c_oneshot: cover property ((state_r == temp_cfg_pkg::ST_SHUT) && oneshot_wr);
   c_shut_mid_conv: cover property (conv_busy && shutdown_ctl ##1 conv_end);
   c_second_overtemp_out_pin: cover property (pin_function_select && mp_pin_oe);
   c_irq_ack: cover property (irq_latch ##1 alert_ack && !any_flag ##1 !irq_latch);

endmodule

// ---- logic/temp_cfg_pkg.sv ----
// constants, types and helpers for the temperature monitor configuration block
// assumes a single 250 MHz clock and a pointer-addressed register port
// Behaviour
// (R01) configuration reads at 03h, writes at 09h, resets to 00h
// (R02) bit 7 gates the interrupt output in interrupt mode only
// (R03) shutdown bit 0 means continuous conversions paced by the rate setting
// (R04) shutdown bit 1 finishes the running conversion, then stops
// (R05) shutdown bit back to 0 resumes continuous conversions
// (R06) in shutdown, each one-shot write starts exactly one conversion; a write during a running conversion is ignored
// (R07) bit 5 picks interrupt output (0) or second over-temperature output (1)
// (R08) bit 2 picks standard 0..127 or extended -64..191 range
// (R09) host writes zero to reserved configuration bits 4, 3, 1, 0
// (R10) rate register reads at 04h, writes at 0Ah, low four bits used
// (R11) rate changes only idle time, never the conversion duration
// (R12) codes 00h..09h give 0.0625..32 per second, doubling; reset 08h
// (R13) local upper threshold reads 05h, writes 0Bh, resets 55h
// (R14) local lower threshold reads 06h, writes 0Ch, resets 00h
// (R15) remote upper threshold byte reads 07h, writes 0Dh, resets 55h
// (R16) interrupt mode: any limit or open flag sets latch, drives pin low
// (R17) second over-temperature mode: only high limit flags drive the pin
// (R18) one-shot register is write-only at 0Fh, any value triggers
// (R19) rate codes above 09h run at the fastest documented rate
// (R20) a written value is seen at the read pointer on the next read

package temp_cfg_pkg;

   localparam logic [7:0] RD_CFG = 8'h03;
   localparam logic [7:0] WR_CFG = 8'h09;
   localparam logic [7:0] RD_RATE = 8'h04;
   localparam logic [7:0] WR_RATE = 8'h0A;
   localparam logic [7:0] RD_LHI = 8'h05;
   localparam logic [7:0] WR_LHI = 8'h0B;
   localparam logic [7:0] RD_LLO = 8'h06;
   localparam logic [7:0] WR_LLO = 8'h0C;
   localparam logic [7:0] RD_RHI = 8'h07;
   localparam logic [7:0] WR_RHI = 8'h0D;
   localparam logic [7:0] WR_ONESHOT = 8'h0F;

   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] RATE_RST = 8'h08;
   localparam logic [7:0] LHI_RST = 8'h55;
   localparam logic [7:0] LLO_RST = 8'h00;
   localparam logic [7:0] RHI_RST = 8'h55;

   localparam int CFG_GATE_BIT = 7;
   localparam int CFG_SD_BIT = 6;
   localparam int CFG_PINF_BIT = 5;
   localparam int CFG_RANGE_BIT = 2;
   // reserved configuration bits are not stored and read as zero
   localparam logic [7:0] CFG_WR_MASK = 8'hE4;
   localparam logic [7:0] RATE_WR_MASK = 8'h0F;
   localparam logic [3:0] RATE_FASTEST = 4'h9;

   localparam int CLK_MHZ = 250;
   localparam int FAST_PERIOD_US = 31250;
   localparam int TICK_CYC = FAST_PERIOD_US * CLK_MHZ;
   localparam int CONV_TIME_US = 12000;
   localparam int CONV_CYC = CONV_TIME_US * CLK_MHZ;
   localparam int PERIOD_W = 10;
   localparam logic [PERIOD_W-1:0] PERIOD_SAT = 10'h3FF;

   typedef enum logic [1:0]
   {
      ST_WAIT = 2'b00,
      ST_CONV = 2'b01,
      ST_SHUT = 2'b10
   } conv_state_t;

   // fastest-period ticks per conversion period: 512 at code 0 down to 1
   function automatic logic [PERIOD_W-1:0] period_ticks(input logic [3:0] code);
      logic [3:0] c;
      c = (code > RATE_FASTEST) ? RATE_FASTEST : code;
      return PERIOD_W'(10'h001 << (RATE_FASTEST - c));
   endfunction

endpackage

// ---- logic/rate_tick.sv ----
// fixed divider giving a one-cycle enable every DIV clocks
// assumes the caller counts ticks in a register; clr preloads 2 so that count
// steps exactly DIV clocks after clr, paying back the tick and count flops (DIV >= 3)
`timescale 1ns/1ps

module rate_tick #(
   parameter int DIV = 7812500
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clr,
   output logic tick
);

   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic wrap;

   assign wrap = (cnt_r == 32'(DIV - 1));

   always_comb
   begin
      if (clr)
      begin
         cnt_nxt = 32'h00000002;
      end
      else if (wrap)
      begin
         cnt_nxt = 32'h00000000;
      end
      else
      begin
         cnt_nxt = cnt_r + 32'h00000001;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_r <= 32'h00000000;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tick <= 1'b0;
      end
      else
      begin
         tick <= wrap && !clr;
      end
   end

endmodule

// ---- tb/reg_host.sv ----
// stand-in for the two-wire host: decoded pointer reads and writes
// assumes rd_valid comes one cycle after the read strobe
`timescale 1ns/1ps

module reg_host
(
   input wire logic clk,
   output logic wr_en,
   output logic [7:0] wr_ptr,
   output logic [7:0] wr_data,
   output logic rd_en,
   output logic [7:0] rd_ptr,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic rd_hit
);
   initial
   begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      wr_ptr = 8'h00;
      wr_data = 8'h00;
      rd_ptr = 8'h00;
   end

   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      @(negedge clk);
      wr_en = 1'b1;
      wr_ptr = p;
      wr_data = (p == temp_cfg_pkg::WR_CFG) ? (d & 8'hE4) : d;
      @(negedge clk);
      wr_en = 1'b0;
      // idle lines must not echo the last value
      wr_ptr = ~wr_ptr;
      wr_data = ~wr_data;
   endtask

   task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic h, output logic v);
      @(negedge clk);
      rd_en = 1'b1;
      rd_ptr = p;
      @(negedge clk);
      rd_en = 1'b0;
      rd_ptr = ~rd_ptr;
      d = rd_data;
      h = rd_hit;
      v = rd_valid;
   endtask
endmodule

// ---- tb/temp_monitor_config_limits_tb.sv ----
// self-checking bench for the configuration and limit block
// assumes shortened pacing counts so the rate codes tested (06h, 09h, 0Ch, 0Fh) fit a short run
`timescale 1ns/1ps

module temp_monitor_config_limits_tb;
   localparam int TICK = 8;
   localparam int CONV = 4;
   logic clk, arst_n, wr_en, rd_en, rd_valid, rd_hit, alert_ack;
   logic [7:0] wr_ptr, wr_data, rd_ptr, rd_data, local_meas, remote_meas;
   logic [4:0] flg;
   logic conv_start, conv_busy, conv_done, local_above, local_below, remote_above;
   logic irq_output_gate, shutdown_ctl, pin_function_select, range_ext;
   logic irq_latch, mp_pin_o, mp_pin_oe;
   logic [3:0] rate_code;
   int bad_count = 0;
   int total_checks = 0;
   int seed = 32'h2177;
   int mreg [8];
   int g, b, k;

   reg_host host (.clk(clk), .wr_en(wr_en), .wr_ptr(wr_ptr), .wr_data(wr_data),
      .rd_en(rd_en), .rd_ptr(rd_ptr), .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit));

   temp_monitor_config_limits #(.TICK_CYC(TICK), .CONV_CYC(CONV)) dut (.clk(clk),
      .arst_n(arst_n), .wr_en(wr_en), .wr_ptr(wr_ptr), .wr_data(wr_data), .rd_en(rd_en),
      .rd_ptr(rd_ptr), .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit),
      .local_meas(local_meas), .remote_meas(remote_meas), .flag_local_high(flg[0]),
      .flag_local_low(flg[1]), .flag_remote_high(flg[2]), .flag_remote_low(flg[3]),
      .flag_open(flg[4]), .alert_ack(alert_ack), .conv_start(conv_start),
      .conv_busy(conv_busy), .conv_done(conv_done), .local_above(local_above),
      .local_below(local_below), .remote_above(remote_above),
      .irq_output_gate(irq_output_gate), .shutdown_ctl(shutdown_ctl),
      .pin_function_select(pin_function_select), .range_ext(range_ext),
      .rate_code(rate_code), .irq_latch(irq_latch), .mp_pin_o(mp_pin_o),
      .mp_pin_oe(mp_pin_oe));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // write through the host and mirror it into the reference copy
   task automatic wr_m(input logic [7:0] p, input logic [7:0] d);
      host.wr(p, d);
      if (p == 8'h09)
         mreg[3] = d & 8'hE4;
      else if (p == 8'h0A)
         mreg[4] = d & 8'h0F;
      else if (p >= 8'h0B && p <= 8'h0D)
         mreg[p - 6] = d;
   endtask

   task automatic rd_chk(input logic [7:0] p);
      logic [7:0] d;
      logic h, v;
      logic m;
      host.rd(p, d, h, v);
      m = (p >= 8'h03 && p <= 8'h07);
      chk("rd_valid", {7'h00, v}, 8'h01);
      chk("rd_hit", {7'h00, h}, {7'h00, m});
      chk("rd_data", d, m ? 8'(mreg[p[2:0]]) : 8'h00);
   endtask

   // spacing between two completions, with busy cycles and compare results
   task automatic gap(output int gg, output int bb);
      int st;
      gg = 0;
      bb = 0;
      st = 0;
      while (conv_done !== 1'b1 && gg < 3000)
      begin
         @(negedge clk);
         gg++;
      end
      // keep a timeout of the first wait so the check below still trips
      gg = (gg >= 3000) ? 3000 : 0;
      do
      begin
         @(negedge clk);
         gg++;
         bb += int'(conv_busy === 1'b1);
         st += int'(conv_start === 1'b1);
      end
      while (conv_done !== 1'b1 && gg < 3000);
      if (gg >= 3000)
      begin
         chk("conv_timeout", 8'h01, 8'h00);
         finish_test();
      end
      chk("conv_start", 8'(st), 8'h01);
      chk("local_above", {7'h00, local_above}, 8'(local_meas > mreg[5]));
      chk("local_below", {7'h00, local_below}, 8'(local_meas < mreg[6]));
      chk("remote_above", {7'h00, remote_above}, 8'(remote_meas > mreg[7]));
   endtask

   task automatic cnt_done(input int n, output int kk);
      kk = 0;
      repeat (n)
      begin
         @(negedge clk);
         kk += int'(conv_done === 1'b1);
      end
   endtask

   task automatic pin_chk(input logic [4:0] f, input logic lat, input logic oe);
      flg = f;
      @(negedge clk);
      chk("irq_latch", {7'h00, irq_latch}, {7'h00, lat});
      chk("mp_pin_oe", {7'h00, mp_pin_oe}, {7'h00, oe});
      flg = 5'h00;
      alert_ack = 1'b1;
      @(negedge clk);
      alert_ack = 1'b0;
   endtask

   initial
   begin
      arst_n = 1'b0;
      flg = 5'h00;
      alert_ack = 1'b0;
      local_meas = 8'($random(seed));
      remote_meas = 8'($random(seed));
      mreg = '{0, 0, 0, 8'h00, 8'h08, 8'h55, 8'h00, 8'h55};
      repeat (5) @(negedge clk);
      arst_n = 1'b1;
      for (int p = 2; p <= 16; p++)
         rd_chk(8'(p));
      $display("test reset values done");
      // 0Eh is unmapped, 0Fh is write-only
      for (int i = 0; i < 14; i++)
      begin
         wr_m(8'(9 + i % 7), 8'($random(seed)));
         for (int p = 3; p <= 7; p++)
            rd_chk(8'(p));
         chk("cfg_bits", {irq_output_gate, shutdown_ctl, pin_function_select, 2'h0,
            range_ext, 2'h0}, 8'(mreg[3]));
         chk("rate_code", {4'h0, rate_code}, 8'(mreg[4]));
      end
      $display("test register access done");
      wr_m(8'h09, 8'h00);
      foreach (mreg[i])
         if (i >= 5)
            wr_m(8'(i + 6), 8'($random(seed)));
      for (int c = 6; c <= 15; c += 3)
      begin
         wr_m(8'h0A, 8'(c));
         gap(g, b);
         gap(g, b);
         chk("spacing", 8'(g), 8'((1 << (9 - ((c > 9) ? 9 : c))) * TICK));
         chk("busy_len", 8'(b), 8'(CONV));
      end
      $display("test pacing done");
      wr_m(8'h0A, 8'h09);
      gap(g, b);
      // land the shutdown write inside the next conversion, not in the idle gap
      repeat (TICK - CONV) @(negedge clk);
      wr_m(8'h09, 8'h40);
      cnt_done(CONV + 2, k);
      chk("finish_running", 8'(k), 8'h01);
      cnt_done(100, k);
      chk("shut_quiet", 8'(k), 8'h00);
      wr_m(8'h0F, 8'($random(seed)));
      cnt_done(100, k);
      chk("one_shot", 8'(k), 8'h01);
      wr_m(8'h09, 8'h00);
      cnt_done(100, k);
      chk("resume", 8'(k > 5), 8'h01);
      $display("test shutdown done");
      for (int f = 0; f < 5; f++)
         pin_chk(5'(1 << f), 1'b1, 1'b1);
      wr_m(8'h09, 8'h80);
      pin_chk(5'h02, 1'b1, 1'b0);
      wr_m(8'h09, 8'h20);
      pin_chk(5'h0A, 1'b0, 1'b0);
      wr_m(8'h09, 8'hA0);
      pin_chk(5'h04, 1'b0, 1'b1);
      chk("mp_pin_o", {7'h00, mp_pin_o}, 8'h00);
      $display("test pin done");
      finish_test();
   end
endmodule
